// File: pec_pkg.sv
// Shared constants for the synthesizer control-word and phase detector logic
package pec_pkg;
  // Control word layout
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned BIT_RSV0    = 0;
  localparam int unsigned BIT_RSV1    = 1;
  localparam int unsigned BIT_FP_MON  = 2;
  localparam int unsigned BIT_PWRDN   = 3;
  localparam int unsigned BIT_CNT_LD  = 4;
  localparam int unsigned BIT_MS_MON  = 5;
  localparam int unsigned BIT_FC_MON  = 6;
  localparam int unsigned BIT_BYPASS  = 7;
  localparam logic [7:0]  WORD_RST    = 8'h00;

  // Pin synchroniser depth and positions of pins in the sampled vector
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned PIN_N       = 8;
  localparam int unsigned PIN_SCLK    = 0;
  localparam int unsigned PIN_SDATA   = 1;
  localparam int unsigned PIN_STROBE  = 2;
  localparam int unsigned PIN_EN_N    = 3;
  localparam int unsigned PIN_DIRECT  = 4;
  localparam int unsigned PIN_FP      = 5;
  localparam int unsigned PIN_FC      = 6;
  localparam int unsigned PIN_MODSEL  = 7;
  localparam logic [7:0]  PIN_RST     = 8'h00;

  // Idle level of the active-low detector outputs
  localparam logic        PFD_IDLE    = 1'b1;
endpackage

// File: pec_sync.sv
// Three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
module pec_sync
  import pec_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk_i,  // System clock
  input  wire logic         rst_n_i,    // Synchronised reset, active low
  input  wire logic [W-1:0] pin_i,      // Asynchronous pin levels
  input  wire logic [W-1:0] rst_val_i,  // Unused reset hint kept for symmetry
  output logic      [W-1:0] level_o     // Filtered, clean levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pec_sync_s;

  pec_sync_s st_q;
  pec_sync_s st_d;

  // Stage one feeds stage two only; the filter looks at stages two and three
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < int'(W); i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  // Constant reset keeps the flops free of port values
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;

  logic unused_rst_val;
  assign unused_rst_val = ^rst_val_i;
endmodule

// File: pec_core.sv
// Control word port, monitor mux, phase detector and lock detect
`timescale 1ns/1ps
module pec_core
  import pec_pkg::*;
(
  input  wire logic              sys_clk_i,               // System clock, 10 MHz
  input  wire logic              rstn_i,                  // Async reset, active low
  input  wire logic              ser_clk_i,               // Serial shift clock pin
  input  wire logic              ser_data_i,              // Serial data pin
  input  wire logic              ser_wr_i,                // Word write strobe pin
  input  wire logic              control_word_enable_n_i, // Control bits enable, low
  input  wire logic              direct_mode_i,           // Direct pin mode select
  input  wire logic              fp_i,                    // Divided VCO signal
  input  wire logic              fc_i,                    // Divided reference signal
  input  wire logic              modulus_select_i,        // Prescaler modulus select
  output logic                   monitor_o,               // Monitor output pin
  output logic                   power_down_o,            // Power-down request
  output logic                   counter_load_o,          // Continuous counter load
  output logic                   prescaler_bypass_o,      // Prescaler bypass
  output logic [WORD_W-1:0]      word_o,                  // Latched control word
  output logic                   pfd_up_n_o,              // Up pulse, active low
  output logic                   pfd_down_n_o,            // Down pulse, active low
  output logic                   lock_filter_node_o,      // Lock filter node drive
  output logic                   lock_indicator_o         // Lock indicator
);
  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // All pins pass the synchroniser
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] lvl;
  always_comb begin
    pins             = '0;
    pins[PIN_SCLK]   = ser_clk_i;
    pins[PIN_SDATA]  = ser_data_i;
    pins[PIN_STROBE] = ser_wr_i;
    pins[PIN_EN_N]   = control_word_enable_n_i;
    pins[PIN_DIRECT] = direct_mode_i;
    pins[PIN_FP]     = fp_i;
    pins[PIN_FC]     = fc_i;
    pins[PIN_MODSEL] = modulus_select_i;
  end

  pec_sync #(
    .W (PIN_N)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .pin_i     (pins),
    .rst_val_i (PIN_RST),
    .level_o   (lvl)
  );

  typedef struct packed {
    logic [PIN_N-1:0]  prev;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] word;
    logic              up_f;
    logic              dn_f;
    logic              mon;
    logic              pwrdn;
    logic              cnt_ld;
    logic              bypass;
    logic              up_n;
    logic              dn_n;
    logic              node;
    logic              lock;
  } pec_state_s;

  pec_state_s st_q;
  pec_state_s st_d;

  // Rising edge of a filtered level
  function automatic logic rise(input logic prev_v, input logic cur_v);
    rise = cur_v & ~prev_v;
  endfunction

  // Effective bit: active high and gated by the enable input
  function automatic logic ctl(input logic [WORD_W-1:0] w, input int unsigned pos,
                               input logic en_n);
    ctl = w[pos] & ~en_n;
  endfunction

  logic sclk_rise;
  logic strobe_fall;
  logic fp_rise;
  logic fc_rise;
  logic en_n;
  logic pd_eff;
  logic fp_sel;
  logic ms_sel;
  logic fc_sel;

  // Edge events and effective controls
  always_comb begin
    sclk_rise   = rise(st_q.prev[PIN_SCLK], lvl[PIN_SCLK]);
    strobe_fall = rise(lvl[PIN_STROBE], st_q.prev[PIN_STROBE]);
    fp_rise     = rise(st_q.prev[PIN_FP], lvl[PIN_FP]);
    fc_rise     = rise(st_q.prev[PIN_FC], lvl[PIN_FC]);
    en_n        = lvl[PIN_EN_N];
    pd_eff      = ctl(st_q.word, BIT_PWRDN, en_n);
    fp_sel      = ctl(st_q.word, BIT_FP_MON, en_n);
    ms_sel      = ctl(st_q.word, BIT_MS_MON, en_n);
    fc_sel      = ctl(st_q.word, BIT_FC_MON, en_n);
  end

  // Next state of the whole block
  always_comb begin
    st_d      = st_q;
    st_d.prev = lvl;
    if (lvl[PIN_STROBE] && sclk_rise) begin
      st_d.shreg = {lvl[PIN_SDATA], st_q.shreg[WORD_W-1:1]};
    end
    if (strobe_fall) begin
      st_d.word = st_q.shreg;
    end
    if (pd_eff) begin
      st_d.up_f = 1'b0;
      st_d.dn_f = 1'b0;
    end else begin
      if (fp_rise) begin
        st_d.dn_f = 1'b1;
      end
      if (fc_rise) begin
        st_d.up_f = 1'b1;
      end
      // Second edge ends the pulse; equal edges give none
      if (st_d.up_f && st_d.dn_f) begin
        st_d.up_f = 1'b0;
        st_d.dn_f = 1'b0;
      end
    end
    st_d.up_n   = ~st_d.up_f;
    st_d.dn_n   = ~st_d.dn_f;
    st_d.node   = ~(st_d.up_n & st_d.dn_n);
    st_d.lock   = ~st_d.node;
    st_d.pwrdn  = pd_eff;
    st_d.cnt_ld = ctl(st_q.word, BIT_CNT_LD, en_n) & ~pd_eff;
    st_d.bypass = ctl(st_q.word, BIT_BYPASS, en_n) & ~lvl[PIN_DIRECT];
    // Fixed priority; several selections are the controller's fault
    if (pd_eff) begin
      st_d.mon = 1'b0;
    end else if (fp_sel) begin
      st_d.mon = lvl[PIN_FP];
    end else if (ms_sel) begin
      st_d.mon = lvl[PIN_MODSEL];
    end else if (fc_sel) begin
      st_d.mon = lvl[PIN_FC];
    end else begin
      st_d.mon = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= '0;
      st_q.word   <= WORD_RST;
      st_q.up_n   <= PFD_IDLE;
      st_q.dn_n   <= PFD_IDLE;
      st_q.lock   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign monitor_o          = st_q.mon;
  assign power_down_o       = st_q.pwrdn;
  assign counter_load_o     = st_q.cnt_ld;
  assign prescaler_bypass_o = st_q.bypass;
  assign word_o             = st_q.word;
  assign pfd_up_n_o         = st_q.up_n;
  assign pfd_down_n_o       = st_q.dn_n;
  assign lock_filter_node_o = st_q.node;
  assign lock_indicator_o   = st_q.lock;

  // Checks
  sequence s_shift_ev;
    lvl[PIN_STROBE] && sclk_rise;
  endsequence

  sequence s_dn_start;
    fp_rise && !fc_rise && !st_q.up_f && !st_q.dn_f && !pd_eff;
  endsequence

  property p_shift;
    @(posedge sys_clk_i) disable iff (!rst_n)
      s_shift_ev |=> st_q.shreg[WORD_W-1] == $past(lvl[PIN_SDATA]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit lost");

  property p_latch;
    @(posedge sys_clk_i) disable iff (!rst_n)
      strobe_fall |=> word_o == $past(st_q.shreg);
  endproperty
  a_latch: assert property (p_latch) else $error("word not latched");

  property p_gate;
    @(posedge sys_clk_i) disable iff (!rst_n)
      en_n |=> !power_down_o && !counter_load_o && !prescaler_bypass_o && !monitor_o;
  endproperty
  a_gate: assert property (p_gate) else $error("bits active while disabled");

  property p_direct;
    @(posedge sys_clk_i) disable iff (!rst_n)
      lvl[PIN_DIRECT] |=> !prescaler_bypass_o;
  endproperty
  a_direct: assert property (p_direct) else $error("bypass in direct mode");

  property p_pwrdn;
    @(posedge sys_clk_i) disable iff (!rst_n)
      power_down_o |-> pfd_up_n_o && pfd_down_n_o && !monitor_o && !counter_load_o;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("activity in power down");

  property p_mon_fp;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (fp_sel && !pd_eff) |=> monitor_o == $past(lvl[PIN_FP]);
  endproperty
  a_mon_fp: assert property (p_mon_fp) else $error("monitor not main divider");

  property p_down;
    @(posedge sys_clk_i) disable iff (!rst_n)
      s_dn_start |=> !pfd_down_n_o && pfd_up_n_o;
  endproperty
  a_down: assert property (p_down) else $error("no down pulse");

  property p_up;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (fc_rise && !fp_rise && !st_q.up_f && !st_q.dn_f && !pd_eff) |=>
        !pfd_up_n_o && pfd_down_n_o;
  endproperty
  a_up: assert property (p_up) else $error("no up pulse");

  property p_end;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (!pfd_down_n_o && !fp_rise && !pd_eff) ##0 (fc_rise && !fp_rise) |=> pfd_down_n_o;
  endproperty
  a_end: assert property (p_end) else $error("down pulse not ended");

  property p_lock;
    @(posedge sys_clk_i) disable iff (!rst_n)
      lock_indicator_o == (pfd_up_n_o && pfd_down_n_o) && lock_filter_node_o != lock_indicator_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock logic wrong");
endmodule

// File: pec_host.sv
// Host model that loads control words over the serial pins
`timescale 1ns/1ps
module pec_host (
  input  wire logic sys_clk_i,  // System clock for pacing
  output logic      ser_clk_o,  // Shift clock pin
  output logic      ser_data_o, // Serial data pin
  output logic      ser_wr_o    // Word write strobe pin
);
  // Shift clock stands low outside frames
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_wr_o = 1'b0;
  end

  // Each level is held long enough for the pin filter
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // LSB first, latch on strobe fall
  task automatic write_word(input logic [7:0] w);
    logic [7:0] v;
    v = w & 8'hFC;
    ser_wr_o = 1'b1;
    hold(6);
    for (int i = 0; i < 8; i++) begin
      ser_data_o = v[i];
      hold(6);
      ser_clk_o = 1'b1;
      hold(6);
      ser_clk_o = 1'b0;
    end
    hold(6);
    ser_wr_o = 1'b0;
    // Idle data shows no stale bit
    ser_data_o = ~v[7];
    hold(8);
  endtask
endmodule

// File: pec_core_bench.sv
// Self-checking bench for the control word and phase detector
`timescale 1ns/1ps
module pec_core_bench;
  import pec_pkg::*;
  logic        clk   = 1'b0;
  logic        rstn  = 1'b0;
  logic        en_n  = 1'b0;
  logic        dmode = 1'b0;
  logic        fp    = 1'b0;
  logic        fc    = 1'b0;
  logic        ms    = 1'b0;
  logic        sclk, sdat, swr, mon, pdn, cld, byp, up_n, dn_n, node, lock;
  logic [7:0]  word;
  int          err_total = 0;
  int          num_checks = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  pec_host pec_host_i (
    .sys_clk_i  (clk),
    .ser_clk_o  (sclk),
    .ser_data_o (sdat),
    .ser_wr_o   (swr)
  );

  pec_core pec_core_i (
    .sys_clk_i               (clk),
    .rstn_i                  (rstn),
    .ser_clk_i               (sclk),
    .ser_data_i              (sdat),
    .ser_wr_i                (swr),
    .control_word_enable_n_i (en_n),
    .direct_mode_i           (dmode),
    .fp_i                    (fp),
    .fc_i                    (fc),
    .modulus_select_i        (ms),
    .monitor_o               (mon),
    .power_down_o            (pdn),
    .counter_load_o          (cld),
    .prescaler_bypass_o      (byp),
    .word_o                  (word),
    .pfd_up_n_o              (up_n),
    .pfd_down_n_o            (dn_n),
    .lock_filter_node_o      (node),
    .lock_indicator_o        (lock)
  );

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Idle levels after reset
  task automatic t_reset;
    chk(8'({up_n, dn_n, lock, node}), 8'h0E, "idle pfd");
    chk(8'({mon, pdn, cld, byp}), 8'h00, "idle ctrl");
    chk(word, WORD_RST, "reset word");
  endtask

  // One monitor source follows its pin
  task automatic t_mon(input logic [7:0] w, input int src);
    pec_host_i.write_word(w);
    chk(word, w, "word");
    case (src)
      0: fp = 1'b1;
      1: ms = 1'b1;
      default: fc = 1'b1;
    endcase
    cyc(8);
    chk(8'(mon), 8'h01, "monitor high");
    fp = 1'b1;
    fc = 1'b1;
    cyc(8);
    fp = 1'b0;
    fc = 1'b0;
    ms = 1'b0;
    cyc(8);
    chk(8'(mon), 8'h00, "monitor low");
  endtask

  // Enable gating and direct mode on bypass
  task automatic t_ctrl;
    pec_host_i.write_word(8'h90);
    en_n = 1'b1;
    cyc(8);
    chk(8'({pdn, cld, byp}), 8'h00, "gated");
    en_n = 1'b0;
    cyc(8);
    chk(8'({pdn, cld, byp}), 8'h03, "load bypass");
    dmode = 1'b1;
    cyc(8);
    chk(8'({pdn, cld, byp}), 8'h02, "direct");
    dmode = 1'b0;
  endtask

  // Pulse side and width, falling edges ignored
  task automatic t_pfd(input logic fp_first, input int gap, input logic pd);
    int   n_up;
    int   n_dn;
    logic act;
    n_up = 0;
    n_dn = 0;
    act = !pd && gap > 0;
    for (int i = 0; i < gap + 20; i++) begin
      cyc(1);
      if (i == 0) begin
        if (fp_first) begin
          fp = 1'b1;
        end else begin
          fc = 1'b1;
        end
      end
      if (i == gap) begin
        fp = 1'b1;
        fc = 1'b1;
      end
      // Staggered falls: a detector fooled by falling edges would pulse
      if (i == gap + 8) begin
        fp = 1'b0;
      end
      if (i == gap + 12) begin
        fc = 1'b0;
      end
      if (up_n === 1'b0) n_up++;
      if (dn_n === 1'b0) n_dn++;
      if (i == 6) chk(8'({node, lock}), act ? 8'h02 : 8'h01, "lock");
    end
    chk(8'(n_dn), (act && fp_first) ? 8'(gap) : 8'h00, "down width");
    chk(8'(n_up), (act && !fp_first) ? 8'(gap) : 8'h00, "up width");
  endtask

  // Main sequence
  initial begin
    cyc(16);
    rstn = 1'b1;
    cyc(6);
    t_reset();
    t_mon(8'h04, 0);
    t_mon(8'h20, 1);
    t_mon(8'h40, 2);
    t_ctrl();
    pec_host_i.write_word(8'h00);
    t_pfd(1'b1, 8, 1'b0);
    t_pfd(1'b0, 12, 1'b0);
    t_pfd(1'b1, 20, 1'b0);
    t_pfd(1'b0, 0, 1'b0);
    // Load and monitor bits set too, so power down must hold them off
    pec_host_i.write_word(8'h1C);
    chk(8'({pdn, cld, mon}), 8'h04, "power down");
    t_pfd(1'b1, 10, 1'b1);
    pec_host_i.write_word(8'h00);
    chk(word, 8'h00, "port alive");
    chk(8'(pdn), 8'h00, "power up");
    report_and_stop();
  end

  // Watchdog cuts a hang short
  initial begin
    #(20000 * 100);
    err_total++;
    report_and_stop();
  end
endmodule
